// ---- rftag_defs.svh ----
`ifndef RFTAG_DEFS_SVH
`define RFTAG_DEFS_SVH
`define RFTAG_CMD_SELECT      8'h25
`define RFTAG_CMD_RESET_READY 8'h26
`define RFTAG_CMD_WRITE_AFI   8'h27
`define RFTAG_CMD_LOCK_AFI    8'h28
`define RFTAG_ERR_OPTION      8'h03
`define RFTAG_ERR_GENERIC     8'h0F
`define RFTAG_ERR_LOCKED      8'h11
`define RFTAG_ERR_WR_LOCKED   8'h12
`define RFTAG_ERR_PROG_FAIL   8'h13
`define RFTAG_ERR_LOCK_FAIL   8'h14
`define RFTAG_FLAG_ERROR_BIT  0
`define RFTAG_FLAG_SELECT_BIT 4
`define RFTAG_FLAG_ADDR_BIT   5
`define RFTAG_FLAG_OPTION_BIT 6
`define RFTAG_RSP_OK          8'h00
`define RFTAG_RSP_ERR         8'h01
`define RFTAG_CRC_PRESET      16'hFFFF
`define RFTAG_CRC_POLY_REFL   16'h8408
`define RFTAG_CRC_RESIDUE     16'hF0B8
`define RFTAG_CLK_MHZ         50
`define RFTAG_NOMINAL_RESPONSE_DELAY_NS        320900
`define RFTAG_WT_SLOT_COUNT   18
`define RFTAG_WT_SLOT_NS      302000
`define RFTAG_WT_NS (`RFTAG_NOMINAL_RESPONSE_DELAY_NS + `RFTAG_WT_SLOT_COUNT * `RFTAG_WT_SLOT_NS)
`define RFTAG_WT_CYCLES (`RFTAG_WT_NS * `RFTAG_CLK_MHZ / 1000)
`define RFTAG_AFI_RESET       8'h00
`endif

// ---- rftag_pkg.sv ----
package rftag_pkg;
    typedef enum logic [5:0] {
        RX_IDLE = 6'h01,
        RX_BODY = 6'h02,
        RX_EXEC = 6'h04,
        RX_PROG = 6'h08,
        RX_RESP = 6'h10,
        RX_DONE = 6'h20
    } rftag_state_t;
    typedef enum logic [1:0] {
        TAG_READY    = 2'h1,
        TAG_SELECTED = 2'h2
    } rftag_mode_t;
    function automatic logic [15:0] rftag_crc_byte(input logic [15:0] crc,
                                                  input logic [7:0]  data);
        logic [15:0] c;
        c = crc ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
        end
        return c;
    endfunction
endpackage

// ---- rftag_if.sv ----
`timescale 1ns/1ps
interface rftag_if;
    logic       reqValid;
    logic       reqSof;
    logic       reqEof;
    logic [7:0] reqByte;
    logic       rspValid;
    logic       rspSof;
    logic       rspEof;
    logic [7:0] rspByte;
    logic       progBusy;
    modport tag (input reqValid, reqSof, reqEof, reqByte,
                 output rspValid, rspSof, rspEof, rspByte, progBusy);
    modport reader (output reqValid, reqSof, reqEof, reqByte,
                    input rspValid, rspSof, rspEof, rspByte, progBusy);
endinterface

// ---- rftag_crc.sv ----
`timescale 1ns/1ps
module rftag_crc (
    input  wire logic        sys_clk,  // clock
    input  wire logic        rst_n,    // async reset
    input  wire logic        clkEn,    // freeze when low
    input  wire logic        init,     // preset the checksum
    input  wire logic        feed,     // fold in one byte
    input  wire logic [7:0]  data,     // byte to fold
    output logic      [15:0] crc       // running checksum
);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            crc <= 16'hFFFF;
        end else if (clkEn) begin
            if (init) begin
                crc <= 16'hFFFF;
            end else if (feed) begin
                crc <= rftag_pkg::rftag_crc_byte(crc, data);
            end
        end
    end
endmodule

// ---- rftag_tag.sv ----
`timescale 1ns/1ps
`include "rftag_defs.svh"
module rftag_tag #(
    parameter logic [63:0] OWN_UID   = 64'hE000_0000_1234_5678,
    parameter int          WT_CYCLES = `RFTAG_WT_CYCLES,
    parameter int          T1_CYCLES = `RFTAG_NOMINAL_RESPONSE_DELAY_NS * `RFTAG_CLK_MHZ / 1000
) (
    input  wire logic       sys_clk,    // 50 MHz clock
    input  wire logic       rst_n,      // async reset, active low
    input  wire logic       clkEn,      // freeze when low
    rftag_if.tag            link,       // frame link to reader
    input  wire logic [7:0] nvAfi,      // stored identifier
    input  wire logic       nvLocked,   // stored lock bit
    input  wire logic       nvFail,     // store reports failure
    output logic            nvWrite,    // store identifier pulse
    output logic            nvLock,     // store lock pulse
    output logic      [7:0] nvData,     // identifier to store
    output logic            selected    // tag in Selected state
);
    localparam int WT_W = $clog2(WT_CYCLES + 1);
    rftag_pkg::rftag_state_t state_q;
    rftag_pkg::rftag_mode_t  mode_q;
    logic [7:0]  buf_q [0:11];
    logic [3:0]  cnt_q;
    logic        over_q;
    logic [WT_W-1:0] tmr_q;
    logic [7:0]  code_q;
    logic        isErr_q;
    logic [1:0]  rspIdx_q;
    logic [2:0]  rspStep_q;
    logic [15:0] crc;
    logic [15:0] rspCrc;
    logic        crcInit;
    logic        crcFeed;
    logic [7:0]  crcData;
    logic [7:0]  flags;
    logic [7:0]  cmd;
    logic        addr;
    logic        uidMatch;
    logic [63:0] rxUid;
    logic [3:0]  needLen;
    logic [7:0]  rxAfi;
    logic [7:0]  rspFlags;

    assign flags = buf_q[0];
    assign cmd   = buf_q[1];
    assign addr  = flags[`RFTAG_FLAG_ADDR_BIT] || cmd == `RFTAG_CMD_SELECT;
    always_comb begin
        rxUid = '0;
        for (int i = 0; i < 8; i++) begin
            rxUid[8*i +: 8] = buf_q[2+i];
        end
    end
    assign uidMatch = !addr || rxUid == OWN_UID;
    assign rxAfi    = addr ? buf_q[10] : buf_q[2];
    // bytes expected including CRC
    always_comb begin
        case (cmd)
            `RFTAG_CMD_WRITE_AFI: needLen = addr ? 4'd13 : 4'd5;
            default:              needLen = addr ? 4'd12 : 4'd4;
        endcase
    end
    assign rspFlags = isErr_q ? `RFTAG_RSP_ERR : `RFTAG_RSP_OK;

    assign crcInit = link.reqValid && link.reqSof || state_q == rftag_pkg::RX_EXEC;
    assign crcFeed = (link.reqValid && state_q == rftag_pkg::RX_BODY && !link.reqEof)
                  || (state_q == rftag_pkg::RX_RESP && link.rspValid && rspStep_q != 3'd0
                      && rspIdx_q < 2'd2
                      && !(rspIdx_q == 2'd1 && !isErr_q));
    assign crcData = state_q == rftag_pkg::RX_RESP ? link.rspByte : link.reqByte;
    rftag_crc u_crc (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clkEn   (clkEn),
        .init    (crcInit),
        .feed    (crcFeed),
        .data    (crcData),
        .crc     (crc)
    );
    assign rspCrc = ~crc;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= 4'd0;
            over_q <= 1'b0;
            for (int i = 0; i < 12; i++) begin
                buf_q[i] <= 8'h00;
            end
        end else if (clkEn && link.reqValid) begin
            if (link.reqSof) begin
                cnt_q  <= 4'd0;
                over_q <= 1'b0;
            end else if (state_q == rftag_pkg::RX_BODY && !link.reqEof) begin
                if (cnt_q < 4'd12) begin
                    buf_q[cnt_q] <= link.reqByte;
                end
                if (cnt_q == 4'd15) begin
                    over_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 4'd1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= rftag_pkg::RX_IDLE;
            mode_q   <= rftag_pkg::TAG_READY;
            tmr_q    <= '0;
            code_q   <= 8'h00;
            isErr_q  <= 1'b0;
            rspIdx_q <= 2'd0;
            nvWrite  <= 1'b0;
            nvLock   <= 1'b0;
            nvData   <= `RFTAG_AFI_RESET;
        end else if (clkEn) begin
            nvWrite <= 1'b0;
            nvLock  <= 1'b0;
            case (state_q)
                rftag_pkg::RX_IDLE: begin
                    if (link.reqValid && link.reqSof) begin
                        state_q <= rftag_pkg::RX_BODY;
                    end
                end
                rftag_pkg::RX_BODY: begin
                    if (link.reqValid && link.reqEof) begin
                        state_q <= rftag_pkg::RX_EXEC;
                    end
                end
                rftag_pkg::RX_EXEC: begin
                    state_q  <= rftag_pkg::RX_DONE;
                    rspIdx_q <= 2'd0;
                    tmr_q    <= WT_W'(T1_CYCLES);
                    isErr_q  <= 1'b0;
                    if (crc != `RFTAG_CRC_RESIDUE || over_q || cnt_q != needLen) begin
                        state_q <= rftag_pkg::RX_IDLE;
                    end else if (cmd == `RFTAG_CMD_SELECT) begin
                        if (!uidMatch) begin
                            if (mode_q == rftag_pkg::TAG_SELECTED) begin
                                mode_q <= rftag_pkg::TAG_READY;
                            end
                        end else if (flags[`RFTAG_FLAG_OPTION_BIT]) begin
                            isErr_q <= 1'b1;
                            code_q  <= `RFTAG_ERR_OPTION;
                            state_q <= rftag_pkg::RX_RESP;
                        end else begin
                            mode_q  <= rftag_pkg::TAG_SELECTED;
                            state_q <= rftag_pkg::RX_RESP;
                        end
                    end else if (!uidMatch) begin
                        state_q <= rftag_pkg::RX_IDLE;
                    end else if (cmd == `RFTAG_CMD_RESET_READY) begin
                        state_q <= rftag_pkg::RX_RESP;
                        if (flags[`RFTAG_FLAG_OPTION_BIT]) begin
                            isErr_q <= 1'b1;
                            code_q  <= `RFTAG_ERR_OPTION;
                        end else begin
                            mode_q <= rftag_pkg::TAG_READY;
                        end
                    end else if (cmd == `RFTAG_CMD_WRITE_AFI) begin
                        if (nvLocked) begin
                            isErr_q <= 1'b1;
                            code_q  <= `RFTAG_ERR_WR_LOCKED;
                            state_q <= rftag_pkg::RX_RESP;
                        end else begin
                            nvWrite <= 1'b1;
                            nvData  <= rxAfi;
                            tmr_q   <= WT_W'(WT_CYCLES);
                            state_q <= rftag_pkg::RX_PROG;
                        end
                    end else if (cmd == `RFTAG_CMD_LOCK_AFI) begin
                        if (nvLocked) begin
                            isErr_q <= 1'b1;
                            code_q  <= `RFTAG_ERR_LOCKED;
                            state_q <= rftag_pkg::RX_RESP;
                        end else begin
                            nvLock  <= 1'b1;
                            tmr_q   <= WT_W'(WT_CYCLES);
                            state_q <= rftag_pkg::RX_PROG;
                        end
                    end else begin
                        state_q <= rftag_pkg::RX_IDLE;
                    end
                end
                rftag_pkg::RX_PROG: begin
                    // option flag ignored: answer only after the cycle ends
                    if (tmr_q != '0) begin
                        tmr_q <= tmr_q - WT_W'(1);
                    end else begin
                        state_q <= rftag_pkg::RX_RESP;
                        if (nvFail) begin
                            isErr_q <= 1'b1;
                            code_q  <= cmd == `RFTAG_CMD_WRITE_AFI ? `RFTAG_ERR_PROG_FAIL
                                                                 : `RFTAG_ERR_LOCK_FAIL;
                        end else if (nvData != nvAfi && cmd == `RFTAG_CMD_WRITE_AFI) begin
                            isErr_q <= 1'b1;
                            code_q  <= `RFTAG_ERR_GENERIC;
                        end
                    end
                end
                rftag_pkg::RX_RESP: begin
                    if (link.rspValid) begin
                        if (link.rspEof) begin
                            state_q <= rftag_pkg::RX_IDLE;
                        end else if (rspStep_q == 3'd0) begin
                            rspIdx_q <= 2'd0;
                        end else if (rspIdx_q == 2'd0 && !isErr_q) begin
                            rspIdx_q <= 2'd2;
                        end else begin
                            rspIdx_q <= rspIdx_q + 2'd1;
                        end
                    end
                end
                rftag_pkg::RX_DONE: begin
                    state_q <= rftag_pkg::RX_IDLE;
                end
                default: begin
                    state_q <= rftag_pkg::RX_IDLE;
                end
            endcase
        end
    end

    // response stream: sof, flags, [code], crc lo, crc hi, eof marker
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rspStep_q <= 3'd0;
        end else if (clkEn) begin
            if (state_q != rftag_pkg::RX_RESP) begin
                rspStep_q <= 3'd0;
            end else if (link.rspValid) begin
                rspStep_q <= rspStep_q + 3'd1;
            end
        end
    end
    assign link.rspValid = state_q == rftag_pkg::RX_RESP;
    assign link.rspSof   = link.rspValid && rspStep_q == 3'd0;
    assign link.rspEof   = link.rspValid && rspStep_q == (isErr_q ? 3'd5 : 3'd4);
    always_comb begin
        case (rspIdx_q)
            2'd0:    link.rspByte = rspFlags;
            2'd1:    link.rspByte = code_q;
            2'd2:    link.rspByte = rspCrc[7:0];
            default: link.rspByte = rspCrc[15:8];
        endcase
    end
    assign link.progBusy = state_q == rftag_pkg::RX_PROG;
    assign selected      = mode_q == rftag_pkg::TAG_SELECTED;
endmodule

// ---- rftag_reader.sv ----
`timescale 1ns/1ps
module rftag_reader (
    input  wire logic        sys_clk,    // 50 MHz clock
    input  wire logic        rst_n,      // async reset, active low
    input  wire logic        clkEn,      // freeze when low
    rftag_if.reader          link,       // frame link to tag
    input  wire logic        cmdStart,   // start one request
    input  wire logic [7:0]  cmdFlags,   // request flags
    input  wire logic [7:0]  cmdCode,    // command code
    input  wire logic [63:0] cmdUid,     // address, sent if flagged or for Select
    input  wire logic [7:0]  cmdAfi,     // identifier for write
    output logic             cmdBusy,    // request in progress
    output logic             rspDone,    // answer byte stream ended
    output logic      [7:0]  rspFlagsQ,  // first answer byte
    output logic      [7:0]  rspCodeQ    // error byte if present
);
    logic [7:0]  frm_q [0:12];
    logic [3:0]  len_q;
    logic [3:0]  idx_q;
    logic        crcPh_q;
    logic [15:0] crc;
    logic [15:0] crcOut;
    logic [15:0] crcNext;
    logic        sendBody;
    logic [1:0]  rspN_q;
    logic        addr;
    assign addr = cmdFlags[5] || cmdCode == 8'h25;
    assign sendBody = cmdBusy && !link.progBusy && idx_q < len_q;
    rftag_crc u_crc (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .clkEn   (clkEn),
        .init    (cmdStart && !cmdBusy),
        .feed    (sendBody && !crcPh_q),
        .data    (frm_q[idx_q]),
        .crc     (crc)
    );
    assign crcOut = ~crc;
    // checksum including the byte being sent this cycle
    assign crcNext = ~rftag_pkg::rftag_crc_byte(crc, frm_q[idx_q]);
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmdBusy <= 1'b0;
            len_q   <= 4'd0;
            idx_q   <= 4'd0;
            crcPh_q <= 1'b0;
            for (int i = 0; i < 13; i++) begin
                frm_q[i] <= 8'h00;
            end
        end else if (clkEn) begin
            if (cmdStart && !cmdBusy) begin
                cmdBusy  <= 1'b1;
                idx_q    <= 4'hF;
                crcPh_q  <= 1'b0;
                frm_q[0] <= cmdFlags;
                frm_q[1] <= cmdCode;
                for (int i = 0; i < 8; i++) begin
                    frm_q[2+i] <= cmdUid[8*i +: 8];
                end
                frm_q[addr ? 10 : 2] <= cmdAfi;
                len_q <= 4'((addr ? 10 : 2) + (cmdCode == 8'h27 ? 1 : 0));
            end else if (cmdBusy && idx_q == 4'hF) begin
                idx_q <= 4'd0;
            end else if (sendBody) begin
                idx_q <= idx_q + 4'd1;
                if (idx_q + 4'd1 == len_q && !crcPh_q) begin
                    crcPh_q <= 1'b1;
                    frm_q[len_q]         <= crcNext[7:0];
                    frm_q[len_q + 4'd1]  <= crcNext[15:8];
                    len_q   <= len_q + 4'd2;
                end
            end else if (cmdBusy && idx_q == len_q) begin
                idx_q <= idx_q + 4'd1;
            end else if (cmdBusy && (rspDone || link.rspEof)) begin
                cmdBusy <= 1'b0;
            end
        end
    end
    assign link.reqValid = cmdBusy && (idx_q == 4'hF || sendBody || idx_q == len_q);
    assign link.reqSof   = cmdBusy && idx_q == 4'hF;
    assign link.reqEof   = cmdBusy && idx_q == len_q && crcPh_q;
    assign link.reqByte  = sendBody ? frm_q[idx_q] : 8'h00;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rspN_q    <= 2'd0;
            rspDone   <= 1'b0;
            rspFlagsQ <= 8'h00;
            rspCodeQ  <= 8'h00;
        end else if (clkEn) begin
            rspDone <= 1'b0;
            if (link.rspValid) begin
                if (link.rspSof) begin
                    rspN_q <= 2'd1;
                end else if (rspN_q == 2'd1) begin
                    rspN_q    <= 2'd2;
                    rspFlagsQ <= link.rspByte;
                end else if (rspN_q == 2'd2) begin
                    rspN_q <= 2'd3;
                    if (rspFlagsQ[0]) begin
                        rspCodeQ <= link.rspByte;
                    end
                end
                if (link.rspEof) begin
                    rspDone <= 1'b1;
                end
            end
        end
    end
endmodule

// ---- rftag_link_properties.sv ----
`timescale 1ns/1ps
module rftag_link_properties #(
    parameter int WT_CYCLES = 20
) (
    input wire logic       sys_clk,  // clock
    input wire logic       rst_n,    // async reset
    input wire logic       reqValid, // request byte strobe
    input wire logic       rspValid, // response strobe
    input wire logic       rspSof,   // response start
    input wire logic       rspEof,   // response end
    input wire logic [7:0] rspByte,  // response byte
    input wire logic       progBusy  // tag programming
);
    int busyN;
    // length of the current programming stretch
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            busyN <= 0;
        else
            busyN <= progBusy ? busyN + 1 : 0;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence okHead;
        rspSof ##1 (rspValid && rspByte == 8'h00);
    endsequence
    sequence errHead;
        rspSof ##1 (rspValid && rspByte == 8'h01);
    endsequence
    chk_quiet_req: assert property (progBusy |-> !reqValid)
        else $error("request while tag programs");
    chk_quiet_rsp: assert property (progBusy |-> !rspValid)
        else $error("response while tag programs");
    chk_flags_byte: assert property (rspSof |=> rspValid && !rspEof && rspByte inside {8'h00, 8'h01})
        else $error("bad response flags byte");
    chk_ok_len: assert property (okHead |-> ##3 rspEof)
        else $error("success response length wrong");
    chk_err_len: assert property (errHead |-> ##4 rspEof)
        else $error("error response length wrong");
    chk_err_code: assert property (errHead |=> rspByte inside {8'h03, 8'h0F, 8'h11, 8'h12, 8'h13, 8'h14})
        else $error("error code not allowed");
    chk_prog_span: assert property ($fell(progBusy) |-> busyN >= WT_CYCLES && busyN <= WT_CYCLES + 2)
        else $error("programming cycle length wrong");
    chk_no_overlap: assert property (rspValid |-> !reqValid)
        else $error("request and response overlap");
    cov_prog: cover property ($rose(progBusy));
endmodule

// ---- rf_tag_select_and_afi_commands_tb_top.sv ----
`timescale 1ns/1ps
`include "rftag_defs.svh"
module rf_tag_select_and_afi_commands_tb_top;
    localparam logic [63:0] UID = 64'h0102_0304_A5B6_C7D8;
    localparam int          WT  = 20;
    logic        sys_clk, rst_n, kick_n, en, start, busy, done, sel, sel2;
    logic        nvLocked, nvFail, nvWrite, nvLock, corrupt;
    logic [7:0]  fl, cd, av, rF, rC, nvAfi, nvData;
    logic [63:0] ud;
    logic [7:0]  rq[$], rs[$];
    int          fails, n_checks, cyc, seed, sawRsp, sawRsp2, eSel, eAfi, eLock;
    rftag_if link();
    rftag_if link2();
    rftag_tag #(.OWN_UID(UID), .WT_CYCLES(WT)) rftag_tag_i (.sys_clk(sys_clk),
        .rst_n(rst_n), .clkEn(en), .link(link), .nvAfi(nvAfi), .nvLocked(nvLocked),
        .nvFail(nvFail), .nvWrite(nvWrite), .nvLock(nvLock), .nvData(nvData), .selected(sel));
    rftag_tag #(.OWN_UID(UID), .WT_CYCLES(WT)) rftag_tag_fault_i (.sys_clk(sys_clk),
        .rst_n(rst_n), .clkEn(en), .link(link2), .nvAfi(nvAfi), .nvLocked(nvLocked),
        .nvFail(nvFail), .nvWrite(), .nvLock(), .nvData(), .selected(sel2));
    rftag_reader rftag_reader_i (.sys_clk(sys_clk), .rst_n(rst_n & kick_n), .clkEn(en),
        .link(link), .cmdStart(start), .cmdFlags(fl), .cmdCode(cd), .cmdUid(ud),
        .cmdAfi(av), .cmdBusy(busy), .rspDone(done), .rspFlagsQ(rF), .rspCodeQ(rC));
    rftag_link_properties #(.WT_CYCLES(WT)) rftag_link_properties_i (.sys_clk(sys_clk),
        .rst_n(rst_n), .reqValid(link.reqValid), .rspValid(link.rspValid),
        .rspSof(link.rspSof), .rspEof(link.rspEof), .rspByte(link.rspByte),
        .progBusy(link.progBusy));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task chk(string nm, logic [63:0] e, logic [63:0] s);
        n_checks++;
        if (s !== e) begin
            $display("[ERR] %s expected %0h seen %0h", nm, e, s);
            fails++;
        end
    endtask
    task finish_test;
        $display("checks %0d errors %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    function automatic logic [15:0] crcOf(logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            repeat (8) c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
        end
        return c;
    endfunction
    // nonvolatile store: survives rst_n on purpose
    always @(posedge sys_clk) begin
        if (nvWrite && !nvFail)
            nvAfi <= nvData ^ {8{corrupt}};
        if (nvLock && !nvFail)
            nvLocked <= 1'b1;
    end
    // wire monitor and hang guard, sampled away from the launching edge
    always @(negedge sys_clk) begin
        cyc++;
        if (link.reqValid && !link.reqSof && !link.reqEof)
            rq.push_back(link.reqByte);
        if (link.reqEof) begin
            chk("req crc", 16'hF0B8, crcOf(rq));
            chk("req len", 4 + 8 * rq[0][5] + (rq[1] == 8'h27), rq.size());
            rq.delete();
        end
        if (link.rspSof)
            sawRsp = 1;
        if (link2.rspSof)
            sawRsp2 = 1;
        if (link.rspValid && !link.rspSof && !link.rspEof)
            rs.push_back(link.rspByte);
        if (link.rspEof) begin
            chk("rsp crc", 16'hF0B8, crcOf(rs));
            chk("rsp len", rs[0][0] ? 4 : 3, rs.size());
            rs.delete();
        end
        if (cyc > 20000) begin
            fails++;
            finish_test();
        end
    end
    task run(logic [7:0] f, logic [7:0] c, logic [63:0] u, logic [7:0] a);
        int m;
        int ec;
        m = !f[5] || u == UID;
        ec = 0;
        if (!m) begin
            if (c == `RFTAG_CMD_SELECT)
                eSel = 0;
        end else if (c < `RFTAG_CMD_WRITE_AFI && f[6])
            ec = `RFTAG_ERR_OPTION;
        else if (c == `RFTAG_CMD_SELECT)
            eSel = 1;
        else if (c == `RFTAG_CMD_RESET_READY)
            eSel = 0;
        else if (c == `RFTAG_CMD_WRITE_AFI)
            ec = eLock ? 8'h12 : nvFail ? 8'h13 : corrupt ? 8'h0F : 0;
        else
            ec = eLock ? 8'h11 : nvFail ? 8'h14 : 0;
        if (m && c == `RFTAG_CMD_WRITE_AFI && !eLock && !nvFail)
            eAfi = a ^ {8{corrupt}};
        if (m && c == `RFTAG_CMD_LOCK_AFI && !eLock && !nvFail)
            eLock = 1;
        sawRsp = 0;
        @(negedge sys_clk);
        start = 1'b1;
        fl = f;
        cd = c;
        ud = u;
        av = a;
        @(negedge sys_clk);
        start = 1'b0;
        if (m) begin
            for (int i = 0; i < 300 && done !== 1'b1; i++) @(negedge sys_clk);
            chk("rsp done", 1, done);
            chk("rsp flags", ec ? 1 : 0, rF);
            if (ec)
                chk("err code", ec, rC);
        end else begin
            repeat (WT + 60) @(negedge sys_clk);
            chk("silence", 0, sawRsp);
            kick_n = 1'b0;
            @(negedge sys_clk);
            kick_n = 1'b1;
        end
        chk("selected", eSel, sel);
        chk("afi", eAfi, nvAfi);
        chk("locked", eLock, nvLocked);
    endtask
    // hand-made Select frames for the second tag, CRC optionally broken
    task raw(logic bad);
        logic [7:0]  q[$];
        logic [15:0] c;
        q = {8'h20, 8'h25};
        for (int i = 0; i < 8; i++) q.push_back(UID[8*i +: 8]);
        c = ~crcOf(q) ^ {15'h0000, bad};
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        sawRsp2 = 0;
        @(negedge sys_clk);
        link2.reqSof = 1'b1;
        link2.reqValid = 1'b1;
        foreach (q[i]) begin
            @(negedge sys_clk);
            link2.reqSof = 1'b0;
            link2.reqValid = 1'b1;
            link2.reqByte = q[i];
        end
        @(negedge sys_clk);
        link2.reqEof = 1'b1;
        @(negedge sys_clk);
        link2.reqValid = 1'b0;
        link2.reqEof = 1'b0;
        repeat (40) @(negedge sys_clk);
        chk("fault answer", !bad, sawRsp2);
        chk("fault selected", !bad, sel2);
    endtask
    initial begin
        {rst_n, start, fl, cd, ud, av, nvLocked, nvFail, corrupt} = '0;
        {link2.reqValid, link2.reqSof, link2.reqEof, link2.reqByte} = '0;
        {kick_n, en} = 2'b11;
        nvAfi = `RFTAG_AFI_RESET;
        {fails, n_checks, cyc, eSel, eAfi, eLock} = '0;
        seed = 32'hdc4c;
        repeat (8) @(negedge sys_clk);
        rst_n = 1'b1;
        raw(1'b1);
        raw(1'b0);
        run(8'h20, 8'h25, UID, 8'h00);
        run(8'h20, 8'h25, UID ^ {$random(seed), 32'h0000_0001}, 8'h00);
        run(8'h20, 8'h25, UID, 8'h00);
        run(8'h60, 8'h25, UID, 8'h00);
        run(8'h60, 8'h26, UID, 8'h00);
        run(8'h60, 8'h26, UID ^ {32'h0000_0010, $random(seed)}, 8'h00);
        run(8'h00, 8'h26, 64'h0, 8'h00);
        nvFail = 1'b1;
        run(8'h00, 8'h27, 64'h0, $random(seed));
        run(8'h00, 8'h28, 64'h0, 8'h00);
        nvFail = 1'b0;
        corrupt = 1'b1;
        run(8'h00, 8'h27, 64'h0, $random(seed));
        corrupt = 1'b0;
        run(8'h40, 8'h27, 64'h0, $random(seed));
        run(8'h20, 8'h27, UID, $random(seed));
        run(8'h00, 8'h28, 64'h0, 8'h00);
        rst_n = 1'b0;
        eSel = 0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        run(8'h00, 8'h27, 64'h0, $random(seed));
        run(8'h20, 8'h28, UID, 8'h00);
        finish_test();
    end
endmodule
